// File: logic/ssosr_otp_mem.sv
module ssosr_otp_mem (
  input wire logic core_clk,
  input wire ssosr_pkg::ssosr_otp_wr_t wr,
  input wire logic [ssosr_pkg::OTP_AW-1:0] rd_addr,
  output logic [ssosr_pkg::BYTE_W-1:0] rd_data
);

  // Contents are loaded by the on-chip programming path; no reset on the array
  logic [ssosr_pkg::BYTE_W-1:0] mem [ssosr_pkg::OTP_DEPTH];

  always_ff @(posedge core_clk)
  begin
    if (wr.en)
    begin
      mem[wr.addr] <= wr.data;
    end
  end

  assign rd_data = mem[rd_addr];

endmodule

// File: logic/ssosr_pkg.sv
package ssosr_pkg;

  localparam logic [7:0] OP_OTP_READ = 8'h4b;
  localparam logic [7:0] OP_SR1_READ = 8'h05;
  localparam logic [7:0] OP_SR2_READ = 8'h35;
  localparam logic [7:0] OP_SR3_READ = 8'h15;
  localparam logic [7:0] OP_SR_IND_READ = 8'h65;

  localparam int BYTE_W = 8;
  localparam int OTP_AW = 9;
  localparam int OTP_DEPTH = 512;
  localparam int SR_COUNT = 6;
  localparam int SR_W = 48;

  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [1:0] ABYTE_HIGH = 2'h0;
  localparam logic [1:0] ABYTE_MID = 2'h1;
  localparam logic [1:0] ABYTE_LOW = 2'h2;
  localparam int OTP_ADDR_MSB_BIT = 8;

  localparam logic [7:0] SR_ADDR_FIRST = 8'h01;
  localparam logic [7:0] SR_ADDR_SECOND = 8'h02;
  localparam logic [7:0] SR_ADDR_THIRD = 8'h03;
  localparam logic [7:0] SR_ADDR_LAST = 8'h06;
  localparam logic [7:0] SR_ADDR_RST = 8'h00;
  localparam logic [8:0] OTP_ADDR_RST = 9'h000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [7:0] UNDEF_BYTE = 8'h00;

  typedef enum logic [2:0] {
    SSOSR_ST_CMD = 3'b000,
    SSOSR_ST_ADDR = 3'b001,
    SSOSR_ST_DUMMY = 3'b010,
    SSOSR_ST_DATA = 3'b011,
    SSOSR_ST_IGNORE = 3'b100
  } ssosr_state_t;

  typedef enum logic [1:0] {
    SSOSR_MODE_OTP = 2'b00,
    SSOSR_MODE_DIRECT = 2'b01,
    SSOSR_MODE_IND = 2'b10
  } ssosr_mode_t;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic si;
  } ssosr_spi_in_t;

  typedef struct packed {
    logic en;
    logic [8:0] addr;
    logic [7:0] data;
  } ssosr_otp_wr_t;

  localparam ssosr_spi_in_t SPI_SYNC_RST = '{cs_n: 1'h1, sclk: 1'h0, si: 1'h0};

endpackage

// File: logic/ssosr_top.sv
// Operation
// - Security and indirect reads: single-line phases
// - 24-bit address, only bits 8:0 used
// - Security bytes shift out MSB first
// - Reading continues across register boundaries
// - Chip select release ends security read
// - Bits 8:7 register, 6:0 byte
// - 05h/35h/15h select status 1/2/3 directly
// - Direct read data follows opcode immediately
// - Direct read repeats the same byte
// - Each repetition shows live status contents
// - Release anytime ends read, output floats
// - 65h, address byte, dummy, then data
// - Addresses 01h-06h map status bytes 1-6
// - Indirect address increments after each byte
// - Data from clock 24, 8 clocks/register
// - Unimplemented addresses give filler, keep going
// - Indirect address wraps FFh to 00h
module ssosr_top (
  input wire logic core_clk,
  input wire logic rstn,
  input wire ssosr_pkg::ssosr_spi_in_t spi_in,
  input wire logic [ssosr_pkg::SR_W-1:0] status_live,
  input wire ssosr_pkg::ssosr_otp_wr_t otp_wr,
  output logic so_o,
  output logic so_oe
);

  ssosr_pkg::ssosr_spi_in_t sync1_q;
  ssosr_pkg::ssosr_spi_in_t sync1_d;
  ssosr_pkg::ssosr_spi_in_t sync2_q;
  ssosr_pkg::ssosr_spi_in_t sync2_d;
  logic sclk_prev_q;
  logic sclk_prev_d;

  ssosr_pkg::ssosr_state_t state_q, state_d;
  ssosr_pkg::ssosr_mode_t mode_q, mode_d;
  logic [2:0] bit_q, bit_d;
  logic [1:0] abyte_q, abyte_d;
  logic [ssosr_pkg::BYTE_W-1:0] shin_q, shin_d;
  logic [ssosr_pkg::OTP_AW-1:0] otp_addr_q, otp_addr_d;
  logic [ssosr_pkg::BYTE_W-1:0] sr_addr_q, sr_addr_d;
  logic [2:0] obit_q, obit_d;
  logic [ssosr_pkg::BYTE_W-1:0] hold_q, hold_d;
  logic so_q, so_d;
  logic oe_q, oe_d;

  logic cs_act;
  logic sclk_rise;
  logic sclk_fall;
  logic [ssosr_pkg::BYTE_W-1:0] byte_in;
  logic [ssosr_pkg::BYTE_W-1:0] otp_byte;
  logic [ssosr_pkg::BYTE_W-1:0] cur_byte;
  logic [ssosr_pkg::BYTE_W-1:0] sr_bytes [ssosr_pkg::SR_COUNT];

  // Pins come from the host's clock domain, so two flops before any use
  always_comb
  begin
    // Plain routing: nothing but the first flop sees the raw pins
    sync1_d = spi_in;
    sync2_d = sync1_q;
    sclk_prev_d = sync2_q.sclk;
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sync1_q <= ssosr_pkg::SPI_SYNC_RST;
      sync2_q <= ssosr_pkg::SPI_SYNC_RST;
      sclk_prev_q <= 1'h0;
    end
    else
    begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      sclk_prev_q <= sclk_prev_d;
    end
  end

  assign cs_act = ~sync2_q.cs_n;
  // Oversampling limits the serial clock to well under a quarter of core_clk
  assign sclk_rise = sync2_q.sclk & ~sclk_prev_q;
  assign sclk_fall = ~sync2_q.sclk & sclk_prev_q;
  assign byte_in = {shin_q[ssosr_pkg::BYTE_W-2:0], sync2_q.si};

  genvar g;
  generate
    for (g = 0; g < ssosr_pkg::SR_COUNT; g++)
    begin : g_sr
      assign sr_bytes[g] = status_live[g*ssosr_pkg::BYTE_W +: ssosr_pkg::BYTE_W];
    end
  endgenerate

  ssosr_otp_mem u_mem (
    .core_clk(core_clk),
    .wr(otp_wr),
    .rd_addr(otp_addr_q),
    .rd_data(otp_byte)
  );

  // Byte on offer to the shifter; it is taken only at bit 7 of each copy
  always_comb
  begin
    cur_byte = ssosr_pkg::UNDEF_BYTE;
    case (mode_q)
      ssosr_pkg::SSOSR_MODE_OTP:
      begin
        cur_byte = otp_byte;
      end
      ssosr_pkg::SSOSR_MODE_DIRECT, ssosr_pkg::SSOSR_MODE_IND:
      begin
        if (sr_addr_q >= ssosr_pkg::SR_ADDR_FIRST && sr_addr_q <= ssosr_pkg::SR_ADDR_LAST)
        begin
          cur_byte = sr_bytes[3'(sr_addr_q - ssosr_pkg::SR_ADDR_FIRST)];
        end
        else
        begin
          cur_byte = ssosr_pkg::UNDEF_BYTE;
        end
      end
      default:
      begin
        // Spare mode code never arises; offer filler rather than stale data
        cur_byte = ssosr_pkg::UNDEF_BYTE;
      end
    endcase
  end

  // All command state moves only on synchronised sclk edges or on chip select release
  always_comb
  begin
    state_d = state_q;
    mode_d = mode_q;
    bit_d = bit_q;
    abyte_d = abyte_q;
    shin_d = shin_q;
    otp_addr_d = otp_addr_q;
    sr_addr_d = sr_addr_q;
    obit_d = obit_q;
    hold_d = hold_q;
    so_d = so_q;
    oe_d = oe_q;
    if (!cs_act)
    begin
      // Release at any bit ends the command and floats the output
      state_d = ssosr_pkg::SSOSR_ST_CMD;
      mode_d = ssosr_pkg::SSOSR_MODE_OTP;
      bit_d = ssosr_pkg::BIT_FIRST;
      abyte_d = ssosr_pkg::ABYTE_HIGH;
      obit_d = ssosr_pkg::BIT_FIRST;
      so_d = 1'h0;
      oe_d = 1'h0;
    end
    else
    begin
      if (sclk_rise)
      begin
        shin_d = byte_in;
        bit_d = bit_q + 3'h1;
        if (bit_q == ssosr_pkg::BIT_LAST)
        begin
          case (state_q)
            ssosr_pkg::SSOSR_ST_CMD:
            begin
              case (byte_in)
                ssosr_pkg::OP_OTP_READ:
                begin
                  mode_d = ssosr_pkg::SSOSR_MODE_OTP;
                  abyte_d = ssosr_pkg::ABYTE_HIGH;
                  state_d = ssosr_pkg::SSOSR_ST_ADDR;
                end
                ssosr_pkg::OP_SR1_READ:
                begin
                  mode_d = ssosr_pkg::SSOSR_MODE_DIRECT;
                  sr_addr_d = ssosr_pkg::SR_ADDR_FIRST;
                  state_d = ssosr_pkg::SSOSR_ST_DATA;
                end
                ssosr_pkg::OP_SR2_READ:
                begin
                  mode_d = ssosr_pkg::SSOSR_MODE_DIRECT;
                  sr_addr_d = ssosr_pkg::SR_ADDR_SECOND;
                  state_d = ssosr_pkg::SSOSR_ST_DATA;
                end
                ssosr_pkg::OP_SR3_READ:
                begin
                  mode_d = ssosr_pkg::SSOSR_MODE_DIRECT;
                  sr_addr_d = ssosr_pkg::SR_ADDR_THIRD;
                  state_d = ssosr_pkg::SSOSR_ST_DATA;
                end
                ssosr_pkg::OP_SR_IND_READ:
                begin
                  mode_d = ssosr_pkg::SSOSR_MODE_IND;
                  state_d = ssosr_pkg::SSOSR_ST_ADDR;
                end
                default:
                begin
                  // Other commands belong to other blocks; stay silent
                  state_d = ssosr_pkg::SSOSR_ST_IGNORE;
                end
              endcase
            end
            ssosr_pkg::SSOSR_ST_ADDR:
            begin
              if (mode_q == ssosr_pkg::SSOSR_MODE_IND)
              begin
                // Any address is taken; unused ones later read as filler
                sr_addr_d = byte_in;
                state_d = ssosr_pkg::SSOSR_ST_DUMMY;
              end
              else
              begin
                abyte_d = abyte_q + 2'h1;
                // Upper address byte and bits 15:9 are dropped
                if (abyte_q == ssosr_pkg::ABYTE_MID)
                begin
                  otp_addr_d[ssosr_pkg::OTP_ADDR_MSB_BIT] = byte_in[0];
                end
                if (abyte_q == ssosr_pkg::ABYTE_LOW)
                begin
                  otp_addr_d[ssosr_pkg::BYTE_W-1:0] = byte_in;
                  state_d = ssosr_pkg::SSOSR_ST_DUMMY;
                end
              end
            end
            ssosr_pkg::SSOSR_ST_DUMMY:
            begin
              state_d = ssosr_pkg::SSOSR_ST_DATA;
            end
            default:
            begin
              state_d = state_q;
            end
          endcase
        end
      end
      if (sclk_fall && state_q == ssosr_pkg::SSOSR_ST_DATA)
      begin
        oe_d = 1'h1;
        obit_d = obit_q + 3'h1;
        if (obit_q == ssosr_pkg::BIT_FIRST)
        begin
          // Byte is captured at bit 7 so each copy is live yet self-consistent
          so_d = cur_byte[ssosr_pkg::BYTE_W-1];
          hold_d = cur_byte;
        end
        else
        begin
          so_d = hold_q[3'(ssosr_pkg::BIT_LAST - obit_q)];
        end
        if (obit_q == ssosr_pkg::BIT_LAST)
        begin
          if (mode_q == ssosr_pkg::SSOSR_MODE_OTP)
          begin
            otp_addr_d = otp_addr_q + 9'h001;
          end
          else if (mode_q == ssosr_pkg::SSOSR_MODE_IND)
          begin
            sr_addr_d = sr_addr_q + 8'h01;
          end
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= ssosr_pkg::SSOSR_ST_CMD;
      mode_q <= ssosr_pkg::SSOSR_MODE_OTP;
      bit_q <= ssosr_pkg::BIT_FIRST;
      abyte_q <= ssosr_pkg::ABYTE_HIGH;
      shin_q <= ssosr_pkg::BYTE_RST;
      otp_addr_q <= ssosr_pkg::OTP_ADDR_RST;
      sr_addr_q <= ssosr_pkg::SR_ADDR_RST;
      obit_q <= ssosr_pkg::BIT_FIRST;
      hold_q <= ssosr_pkg::BYTE_RST;
      so_q <= 1'h0;
      oe_q <= 1'h0;
    end
    else
    begin
      state_q <= state_d;
      mode_q <= mode_d;
      bit_q <= bit_d;
      abyte_q <= abyte_d;
      shin_q <= shin_d;
      otp_addr_q <= otp_addr_d;
      sr_addr_q <= sr_addr_d;
      obit_q <= obit_d;
      hold_q <= hold_d;
      so_q <= so_d;
      oe_q <= oe_d;
    end
  end

  // Both pins come straight from registers so they never glitch
  assign so_o = so_q;
  assign so_oe = oe_q;

endmodule

// File: tb/ssosr_checker.sv
module ssosr_checker (
  input wire logic core_clk,
  input wire logic rstn,
  input wire ssosr_pkg::ssosr_spi_in_t spi_in,
  input wire logic [ssosr_pkg::SR_W-1:0] status_live,
  input wire ssosr_pkg::ssosr_otp_wr_t otp_wr,
  input wire logic so_o,
  input wire logic so_oe
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  a_undriven_pin_low: assert property (!so_oe |-> !so_o)
    else $error("so_o high while not driven");
  a_quiet_after_reset: assert property ($rose(rstn) |-> !so_oe && !so_o)
    else $error("output active right after reset");
  a_release_floats: assert property ($rose(spi_in.cs_n) |-> ##[1:6] !so_oe)
    else $error("so_oe still high after deselect");
  a_deselect_idle: assert property (spi_in.cs_n [*5] |-> !so_oe)
    else $error("so_oe high while deselected");
  a_oe_holds: assert property (so_oe && !spi_in.cs_n |=> so_oe)
    else $error("so_oe dropped while selected");
  a_no_early_data: assert property ($fell(spi_in.cs_n) |-> !so_oe [*8])
    else $error("so_oe rose before any command");
  a_oe_on_fall: assert property ($rose(so_oe) |-> !spi_in.cs_n && !spi_in.sclk)
    else $error("so_oe rose outside a low sclk phase");
  a_shift_on_fall: assert property (so_oe && $changed(so_o) |-> !spi_in.sclk)
    else $error("so_o changed while sclk high");
  a_steady_high: assert property ($rose(spi_in.sclk) |=> $stable(so_o) [*4])
    else $error("so_o moved after an sclk rise");
endmodule

bind ssosr_top ssosr_checker u_checker (.core_clk(core_clk), .rstn(rstn), .spi_in(spi_in),
  .status_live(status_live), .otp_wr(otp_wr), .so_o(so_o), .so_oe(so_oe));

// File: tb/ssosr_host.sv
module ssosr_host (
  input wire logic core_clk,
  input wire logic so_o,
  output ssosr_pkg::ssosr_spi_in_t spi
);
  timeunit 1ns;
  timeprecision 1ns;

  logic idle_hi = 1'h0;

  initial spi = ssosr_pkg::SPI_SYNC_RST;

  // Six core cycles per phase leaves margin over the two-flop pin synchroniser
  task automatic half();
    repeat (6) @(negedge core_clk);
  endtask

  task automatic sel();
    spi.cs_n = 1'h0;
    half();
  endtask

  // Clock level while deselected: low for mode 0, high for mode 3
  task automatic idle(input logic hi);
    idle_hi = hi;
    spi.sclk = hi;
    half();
  endtask

  // Each bit opens with its falling edge; in mode 3 the leading one is a dummy
  task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--)
    begin
      spi.sclk = 1'h0;
      spi.si = tx[i];
      half();
      rx = {rx[6:0], so_o};
      spi.sclk = 1'h1;
      half();
    end
  endtask

  task automatic unsel();
    if (!idle_hi)
      spi.sclk = 1'h0;
    half();
    spi.cs_n = 1'h1;
    // A released data line must not keep showing its last bit
    spi.si = ~spi.si;
    half();
  endtask
endmodule

// File: tb/test_serial_flash_otp_status_read.sv
module test_serial_flash_otp_status_read;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [47:0] S0 = 48'h5a3c_96e7_81c3;
  localparam logic [47:0] S1 = 48'ha5c3_1e69_7f0d;
  localparam logic [7:0] DOP [3] = '{ssosr_pkg::OP_SR1_READ, ssosr_pkg::OP_SR2_READ,
    ssosr_pkg::OP_SR3_READ};
  localparam logic [8:0] OA [4] = '{9'h07f, 9'h080, 9'h1ff, 9'h000};
  localparam logic [8:0] OS [2] = '{9'h07f, 9'h1ff};
  localparam logic [7:0] IA [2] = '{8'h01, 8'hfe};

  logic core_clk;
  logic rstn;
  ssosr_pkg::ssosr_spi_in_t spi_in;
  logic [47:0] status_live;
  ssosr_pkg::ssosr_otp_wr_t otp_wr;
  logic so_o;
  logic so_oe;
  logic [7:0] rd [8];
  logic [7:0] r1;
  logic [7:0] r2;
  logic oe_seen;
  int n_mismatch = 0;
  int samples_checked = 0;

  ssosr_top dut (.core_clk(core_clk), .rstn(rstn), .spi_in(spi_in), .status_live(status_live),
    .otp_wr(otp_wr), .so_o(so_o), .so_oe(so_oe));
  ssosr_host host (.core_clk(core_clk), .so_o(so_o), .spi(spi_in));

  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) oe_seen <= oe_seen | so_oe;

  function automatic logic [7:0] sb(input logic [47:0] s, input int k);
    return (k >= 1 && k <= 6) ? s[8*k-8 +: 8] : 8'h00;
  endfunction

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic frame(input logic [7:0] op, input logic [31:0] hdr, input int nh, input int nb);
    host.sel();
    host.xfer(op, 8, r1);
    for (int i = nh - 1; i >= 0; i--)
      host.xfer(hdr[8*i +: 8], 8, r1);
    for (int i = 0; i < nb; i++)
      host.xfer(8'h00, 8, rd[i]);
    host.unsel();
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    end_of_test();
  end

  initial
  begin
    core_clk = 1'h0;
    rstn = 1'h0;
    status_live = S0;
    otp_wr = '0;
    oe_seen = 1'h0;
    repeat (4) @(negedge core_clk);
    rstn = 1'h1;
    chk("so_oe after reset", 8'h00, {7'h00, so_oe});
    foreach (OA[i])
    begin
      otp_wr = '{en: 1'h1, addr: OA[i], data: OA[i][7:0] ^ 8'ha5};
      @(negedge core_clk);
    end
    otp_wr = '0;
    // Upper address bits all ones; reads cross a register boundary and the top end
    foreach (OS[j])
    begin
      frame(ssosr_pkg::OP_OTP_READ, {15'h7fff, OS[j], 8'h00}, 4, 2);
      for (int i = 0; i < 2; i++)
        chk("otp byte", 8'(OS[j] + i) ^ 8'ha5, rd[i]);
    end
    $display("test otp read done");
    foreach (DOP[k])
    begin
      status_live = S0;
      host.sel();
      host.xfer(DOP[k], 8, r1);
      host.xfer(8'h00, 4, r1);
      status_live = S1;
      host.xfer(8'h00, 4, r2);
      chk("direct copy one", sb(S0, k + 1), {r1[3:0], r2[3:0]});
      host.xfer(8'h00, 8, r1);
      chk("direct copy two", sb(S1, k + 1), r1);
      host.xfer(8'h00, 3, r1);
      host.unsel();
      chk("so_oe mid-byte release", 8'h00, {7'h00, so_oe});
    end
    $display("test direct read done");
    rstn = 1'h0;
    repeat (2) @(negedge core_clk);
    rstn = 1'h1;
    repeat (3) @(negedge core_clk);
    foreach (IA[j])
    begin
      frame(ssosr_pkg::OP_SR_IND_READ, {16'h0000, IA[j], 8'h00}, 2, 7);
      for (int i = 0; i < 7; i++)
        chk("indirect byte", sb(S1, 8'(IA[j] + i)), rd[i]);
    end
    $display("test indirect read done");
    oe_seen = 1'h0;
    frame(8'h9f, 32'h0000_0000, 0, 2);
    chk("unknown opcode output", 8'h00, rd[1]);
    chk("unknown opcode enable", 8'h00, {7'h00, oe_seen});
    $display("test unknown opcode done");
    host.idle(1'h1);
    frame(ssosr_pkg::OP_SR1_READ, 32'h0000_0000, 0, 2);
    for (int i = 0; i < 2; i++)
      chk("mode 3 direct byte", sb(S1, 1), rd[i]);
    frame(ssosr_pkg::OP_SR_IND_READ, {16'h0000, 8'h06, 8'h00}, 2, 2);
    chk("mode 3 indirect byte", sb(S1, 6), rd[0]);
    chk("mode 3 past last", 8'h00, rd[1]);
    $display("test clock mode 3 done");
    end_of_test();
  end
endmodule
